// ---- logic/asm_cfg.svh ----
// Offsets, fields, reset values and encodings of the subtract datapath
`ifndef ASM_CFG_SVH
`define ASM_CFG_SVH

`define ASM_ADDR_W       12
`define ASM_OFS_CTRL     12'h000
`define ASM_OFS_STATUS   12'h004
`define ASM_OFS_ACC      12'h008
`define ASM_OFS_INSTR    12'h00c
`define ASM_OFS_TIMING   12'h010
`define ASM_OFS_AUX      12'h014
`define ASM_OFS_CYCLES   12'h018
`define ASM_DMEM_SEL     3'h1

`define ASM_CTRL_SGN     0
`define ASM_CTRL_SAT     1
`define ASM_CTRL_CARRY   2
`define ASM_CTRL_WRAP    3
`define ASM_STAT_BUSY    0
`define ASM_STAT_BADOP   1

`define ASM_TIM_PLOC_LO  0
`define ASM_TIM_DEXT     2
`define ASM_TIM_D_LO     4
`define ASM_TIM_P_LO     8
`define ASM_TIM_RPT_LO   16

`define ASM_PLOC_PI      2'h0
`define ASM_PLOC_PE      2'h1
`define ASM_PLOC_PR      2'h2

`define ASM_OPC_BORROW   8'h4f
`define ASM_OPC_COND     8'h47
`define ASM_OPC_HIGH     8'h44
`define ASM_OPC_IND_BIT  7

`define ASM_COND_SHIFT   15
`define ASM_SAT_POS      32'h7fffffff
`define ASM_SAT_NEG      32'h80000000
`define ASM_RST_CARRY    1'b1

`endif

// ---- logic/asm_pkg.sv ----
// Types shared by the subtract datapath modules
package asm_pkg;
    typedef enum logic [1:0] {
        ASM_OP_BORROW,
        ASM_OP_COND,
        ASM_OP_HIGH
    } asm_op_e;

    typedef enum logic [1:0] {
        ASM_ST_IDLE,
        ASM_ST_RUN,
        ASM_ST_TAIL
    } asm_state_e;
endpackage : asm_pkg

// ---- logic/asm_op_if.sv ----
// Operand and result bundle between sequencer and subtract ALU
`timescale 1ns/1ps
`default_nettype none
interface asm_op_if;
    import asm_pkg::*;
    asm_op_e     op_sel;
    logic [31:0] acc;
    logic [15:0] dm_word;
    logic        sgn;
    logic        sat;
    logic        carry;
    logic [31:0] res_acc;
    logic        res_carry;
    logic        res_ov;

    modport alu  (input op_sel, acc, dm_word, sgn, sat, carry,
                  output res_acc, res_carry, res_ov);
    modport core (output op_sel, acc, dm_word, sgn, sat, carry,
                  input res_acc, res_carry, res_ov);
endinterface : asm_op_if
`default_nettype wire

// ---- logic/asm_sub_alu.sv ----
// One iteration of the three subtract operations
`timescale 1ns/1ps
`default_nettype none
`include "asm_cfg.svh"
module asm_sub_alu
    import asm_pkg::*;
(
    asm_op_if.alu op
);
    logic [31:0] ext32;
    logic [31:0] opnd;
    logic        bin;
    logic [33:0] r34;
    logic [32:0] u33;
    logic        borrow;
    logic        ovf;
    logic [31:0] clamp;

    always_comb begin
        ext32 = op.sgn ? {{16{op.dm_word[15]}}, op.dm_word} : {16'h0, op.dm_word};
        opnd  = {16'h0, op.dm_word};
        bin   = 1'b0;
        unique case (op.op_sel)
            ASM_OP_BORROW: begin
                opnd = {16'h0, op.dm_word};
                bin  = ~op.carry;
            end
            ASM_OP_COND: begin
                opnd = {ext32[16:0], 15'h0};
            end
            ASM_OP_HIGH: begin
                opnd = {op.dm_word, 16'h0};
            end
            default: begin
                opnd = {16'h0, op.dm_word};
            end
        endcase
        r34    = {{2{op.acc[31]}}, op.acc} - {{2{opnd[31]}}, opnd} - {33'h0, bin};
        u33    = {1'b0, op.acc} - {1'b0, opnd} - {32'h0, bin};
        borrow = u33[32];
        ovf    = r34[32] != r34[31];
        clamp  = r34[33] ? `ASM_SAT_NEG : `ASM_SAT_POS;
        op.res_ov    = ovf;
        op.res_acc   = r34[31:0];
        op.res_carry = ~borrow;
        unique case (op.op_sel)
            ASM_OP_BORROW: begin
                op.res_acc   = (ovf && op.sat) ? clamp : r34[31:0];
                op.res_carry = ~borrow;
            end
            ASM_OP_COND: begin
                // No clamping here, whatever the saturation setting
                op.res_acc   = r34[31] ? {op.acc[30:0], 1'b0}
                                       : {r34[30:0], 1'b1};
                op.res_carry = ~borrow;
            end
            ASM_OP_HIGH: begin
                op.res_acc   = (ovf && op.sat) ? clamp : r34[31:0];
                op.res_carry = borrow ? 1'b0 : op.carry;
            end
            default: begin
                op.res_acc   = op.acc;
                op.res_carry = op.carry;
            end
        endcase
    end
endmodule : asm_sub_alu
`default_nettype wire

// ---- logic/asm_top.sv ----
// Subtract datapath with data memory, sequencer and Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
`include "asm_cfg.svh"
module asm_top
    import asm_pkg::*;
#(
    parameter int DM_AW = 7
) (
    input  wire logic                   CLK_I,
    input  wire logic                   ARST_N_I,
    input  wire logic                   CE_I,
    input  wire logic [`ASM_ADDR_W-1:0] AVS_ADDRESS_I,
    input  wire logic                   AVS_READ_I,
    input  wire logic                   AVS_WRITE_I,
    input  wire logic [31:0]            AVS_WRITEDATA_I,
    input  wire logic [3:0]             AVS_BYTEENABLE_I,
    output logic [31:0]                 AVS_READDATA_O,
    output logic                        AVS_WAITREQUEST_O,
    output logic                        BUSY_O
);
    localparam int DM_DEPTH = 1 << DM_AW;

    asm_op_if alu_bus ();

    asm_sub_alu u_alu (
        .op (alu_bus.alu)
    );

    // Control and status
    logic             sgn,        next_sgn;
    logic             sat,        next_sat;
    logic             carry,      next_carry;
    logic             wrap,       next_wrap;
    logic             bad_op,     next_bad_op;
    logic [31:0]      acc,        next_acc;
    logic [15:0]      opcode,     next_opcode;
    logic [1:0]       prog_loc,   next_prog_loc;
    logic             data_ext,   next_data_ext;
    logic [3:0]       d_wait,     next_d_wait;
    logic [3:0]       p_wait,     next_p_wait;
    logic [7:0]       rpt,        next_rpt;
    logic [DM_AW-1:0] aux_addr,   next_aux_addr;
    logic [15:0]      last_cyc,   next_last_cyc;
    // Sequencer
    asm_state_e       state,      next_state;
    asm_op_e          cur_op,     next_cur_op;
    logic [DM_AW-1:0] eff_addr,   next_eff_addr;
    logic [8:0]       iter_left,  next_iter_left;
    logic [15:0]      tail_left,  next_tail_left;
    // Bus answer
    logic             waitreq,    next_waitreq;
    logic             busy,       next_busy;
    logic [31:0]      rdata,      next_rdata;
    logic [15:0]      dmem [DM_DEPTH];

    logic             req;
    logic             take;
    logic             wr_take;
    logic             in_dmem;
    logic [DM_AW-1:0] dm_idx;
    logic [31:0]      wmask;
    logic [8:0]       n_iter;
    logic [15:0]      extra;
    logic             legal;
    asm_op_e          dec_op;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [31:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction : merge

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{AVS_BYTEENABLE_I[b]}};
        end
    end

    assign req     = AVS_READ_I | AVS_WRITE_I;
    // Writes wait while an operation runs, reads are served at once
    assign take    = req && waitreq && !(AVS_WRITE_I && state != ASM_ST_IDLE);
    assign wr_take = take && AVS_WRITE_I;
    assign in_dmem = AVS_ADDRESS_I[`ASM_ADDR_W-1:9] == `ASM_DMEM_SEL;
    assign dm_idx  = AVS_ADDRESS_I[DM_AW+1:2];

    // Opcode decode
    always_comb begin
        legal  = 1'b1;
        dec_op = ASM_OP_BORROW;
        unique case (AVS_WRITEDATA_I[15:8])
            `ASM_OPC_BORROW: dec_op = ASM_OP_BORROW;
            `ASM_OPC_COND:   dec_op = ASM_OP_COND;
            `ASM_OPC_HIGH:   dec_op = ASM_OP_HIGH;
            default:         legal  = 1'b0;
        endcase
    end

    // Cycle cost of the issued operation
    always_comb begin
        n_iter = {1'b0, rpt} + 9'h001;
        extra  = 16'h0000;
        if (data_ext) begin
            extra = 16'h0001 + ({7'h00, n_iter} * {12'h000, d_wait});
        end
        if (prog_loc == `ASM_PLOC_PE) begin
            extra = extra + {12'h000, p_wait};
        end
    end

    assign alu_bus.op_sel  = cur_op;
    assign alu_bus.acc     = acc;
    assign alu_bus.dm_word = dmem[eff_addr];
    assign alu_bus.sgn     = sgn;
    assign alu_bus.sat     = sat;
    assign alu_bus.carry   = carry;

    always_comb begin
        next_sgn       = sgn;
        next_sat       = sat;
        next_carry     = carry;
        next_wrap      = wrap;
        next_bad_op    = bad_op;
        next_acc       = acc;
        next_opcode    = opcode;
        next_prog_loc  = prog_loc;
        next_data_ext  = data_ext;
        next_d_wait    = d_wait;
        next_p_wait    = p_wait;
        next_rpt       = rpt;
        next_aux_addr  = aux_addr;
        next_last_cyc  = last_cyc;
        next_state     = state;
        next_cur_op    = cur_op;
        next_eff_addr  = eff_addr;
        next_iter_left = iter_left;
        next_tail_left = tail_left;
        next_waitreq   = !take;
        next_rdata     = rdata;

        unique case (state)
            ASM_ST_IDLE: begin
            end
            ASM_ST_RUN: begin
                // One iteration per cycle on the same operand
                next_acc       = alu_bus.res_acc;
                next_carry     = alu_bus.res_carry;
                next_wrap      = wrap | alu_bus.res_ov;
                next_iter_left = iter_left - 9'h001;
                if (iter_left == 9'h001) begin
                    next_state = (tail_left == 16'h0000) ? ASM_ST_IDLE : ASM_ST_TAIL;
                end
            end
            ASM_ST_TAIL: begin
                next_tail_left = tail_left - 16'h0001;
                if (tail_left == 16'h0001) begin
                    next_state = ASM_ST_IDLE;
                end
            end
            default: begin
                next_state = ASM_ST_IDLE;
            end
        endcase

        if (take && AVS_READ_I) begin
            next_rdata = 32'h0;
            if (!in_dmem) begin
                unique case (AVS_ADDRESS_I)
                    `ASM_OFS_CTRL: begin
                        next_rdata[`ASM_CTRL_SGN]   = sgn;
                        next_rdata[`ASM_CTRL_SAT]   = sat;
                        next_rdata[`ASM_CTRL_CARRY] = carry;
                        next_rdata[`ASM_CTRL_WRAP]  = wrap;
                    end
                    `ASM_OFS_STATUS: begin
                        next_rdata[`ASM_STAT_BUSY]  = state != ASM_ST_IDLE;
                        next_rdata[`ASM_STAT_BADOP] = bad_op;
                    end
                    `ASM_OFS_ACC:    next_rdata = acc;
                    `ASM_OFS_INSTR:  next_rdata = {16'h0, opcode};
                    `ASM_OFS_TIMING: begin
                        next_rdata[`ASM_TIM_PLOC_LO +: 2] = prog_loc;
                        next_rdata[`ASM_TIM_DEXT]         = data_ext;
                        next_rdata[`ASM_TIM_D_LO +: 4]    = d_wait;
                        next_rdata[`ASM_TIM_P_LO +: 4]    = p_wait;
                        next_rdata[`ASM_TIM_RPT_LO +: 8]  = rpt;
                    end
                    `ASM_OFS_AUX:    next_rdata[DM_AW-1:0] = aux_addr;
                    `ASM_OFS_CYCLES: next_rdata = {16'h0, last_cyc};
                    default:         next_rdata = 32'h0;
                endcase
            end else begin
                next_rdata = {16'h0, dmem[dm_idx]};
            end
        end

        if (wr_take && !in_dmem) begin
            unique case (AVS_ADDRESS_I)
                `ASM_OFS_CTRL: begin
                    if (AVS_BYTEENABLE_I[0]) begin
                        next_sgn   = AVS_WRITEDATA_I[`ASM_CTRL_SGN];
                        next_sat   = AVS_WRITEDATA_I[`ASM_CTRL_SAT];
                        next_carry = AVS_WRITEDATA_I[`ASM_CTRL_CARRY];
                        next_wrap  = AVS_WRITEDATA_I[`ASM_CTRL_WRAP];
                    end
                end
                `ASM_OFS_ACC: next_acc = merge(acc, AVS_WRITEDATA_I, wmask);
                `ASM_OFS_INSTR: begin
                    if (AVS_BYTEENABLE_I[1:0] == 2'h3) begin
                        next_opcode = AVS_WRITEDATA_I[15:0];
                        next_bad_op = !legal;
                        if (legal) begin
                            next_cur_op    = dec_op;
                            next_eff_addr  = AVS_WRITEDATA_I[`ASM_OPC_IND_BIT]
                                           ? aux_addr
                                           : AVS_WRITEDATA_I[DM_AW-1:0];
                            next_iter_left = n_iter;
                            next_tail_left = extra;
                            next_last_cyc  = {7'h00, n_iter} + extra;
                            next_state     = ASM_ST_RUN;
                        end
                    end
                end
                `ASM_OFS_TIMING: begin
                    if (AVS_BYTEENABLE_I[0]) begin
                        next_prog_loc = AVS_WRITEDATA_I[`ASM_TIM_PLOC_LO +: 2];
                        next_data_ext = AVS_WRITEDATA_I[`ASM_TIM_DEXT];
                        next_d_wait   = AVS_WRITEDATA_I[`ASM_TIM_D_LO +: 4];
                    end
                    if (AVS_BYTEENABLE_I[1]) begin
                        next_p_wait = AVS_WRITEDATA_I[`ASM_TIM_P_LO +: 4];
                    end
                    if (AVS_BYTEENABLE_I[2]) begin
                        next_rpt = AVS_WRITEDATA_I[`ASM_TIM_RPT_LO +: 8];
                    end
                end
                `ASM_OFS_AUX: begin
                    if (AVS_BYTEENABLE_I[0]) begin
                        next_aux_addr = AVS_WRITEDATA_I[DM_AW-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        next_busy      = next_state != ASM_ST_IDLE;
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sgn       <= 1'b0;
            sat       <= 1'b0;
            carry     <= `ASM_RST_CARRY;
            wrap      <= 1'b0;
            bad_op    <= 1'b0;
            acc       <= 32'h0;
            opcode    <= 16'h0;
            prog_loc  <= `ASM_PLOC_PI;
            data_ext  <= 1'b0;
            d_wait    <= 4'h0;
            p_wait    <= 4'h0;
            rpt       <= 8'h00;
            aux_addr  <= '0;
            last_cyc  <= 16'h0;
            state     <= ASM_ST_IDLE;
            cur_op    <= ASM_OP_BORROW;
            eff_addr  <= '0;
            iter_left <= 9'h000;
            tail_left <= 16'h0;
            waitreq   <= 1'b1;
            busy      <= 1'b0;
            rdata     <= 32'h0;
        end else if (CE_I) begin
            sgn       <= next_sgn;
            sat       <= next_sat;
            carry     <= next_carry;
            wrap      <= next_wrap;
            bad_op    <= next_bad_op;
            acc       <= next_acc;
            opcode    <= next_opcode;
            prog_loc  <= next_prog_loc;
            data_ext  <= next_data_ext;
            d_wait    <= next_d_wait;
            p_wait    <= next_p_wait;
            rpt       <= next_rpt;
            aux_addr  <= next_aux_addr;
            last_cyc  <= next_last_cyc;
            state     <= next_state;
            cur_op    <= next_cur_op;
            eff_addr  <= next_eff_addr;
            iter_left <= next_iter_left;
            tail_left <= next_tail_left;
            waitreq   <= next_waitreq;
            busy      <= next_busy;
            rdata     <= next_rdata;
        end
    end

    // Data memory words, no reset
    always_ff @(posedge CLK_I) begin
        if (CE_I && wr_take && in_dmem) begin
            dmem[dm_idx] <= (dmem[dm_idx] & ~wmask[15:0])
                            | (AVS_WRITEDATA_I[15:0] & wmask[15:0]);
        end
    end

    assign AVS_READDATA_O    = rdata;
    assign AVS_WAITREQUEST_O = waitreq;
    assign BUSY_O            = busy;
endmodule : asm_top
`default_nettype wire

// ---- tb/asm_host.sv ----
// Avalon-MM master model standing in for software on the register bus
`timescale 1ns/1ps
`default_nettype none
module asm_host (
    input  wire logic        clk_i,
    input  wire logic        wait_i,
    input  wire logic [31:0] rdata_i,
    output logic      [11:0] addr_o,
    output logic             rd_o,
    output logic             wr_o,
    output logic      [31:0] wdata_o
);
    initial begin
        addr_o  = 12'h0;
        rd_o    = 1'b0;
        wr_o    = 1'b0;
        wdata_o = 32'h0;
    end

    // Request held until the edge that samples waitrequest low
    task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        rd_o    <= ~w;
        wr_o    <= w;
        @(posedge clk_i);
        while (wait_i !== 1'b0) @(posedge clk_i);
        q = rdata_i;
        rd_o    <= 1'b0;
        wr_o    <= 1'b0;
        wdata_o <= ~d;
    endtask : access
endmodule : asm_host
`default_nettype wire

// ---- tb/asm_top_asserts.sv ----
// Bus handshake and cycle cost checks on the subtract datapath
`timescale 1ns/1ps
`default_nettype none
`include "asm_cfg.svh"
module asm_top_asserts #(
    parameter int DM_AW = 7
) (
    input wire logic        CLK_I,
    input wire logic        ARST_N_I,
    input wire logic        CE_I,
    input wire logic [11:0] AVS_ADDRESS_I,
    input wire logic        AVS_READ_I,
    input wire logic        AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0]  AVS_BYTEENABLE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic        AVS_WAITREQUEST_O,
    input wire logic        BUSY_O
);
    logic [31:0] tim;
    logic [31:0] run_len;
    logic [31:0] n;
    logic [31:0] cost;
    logic        legal;

    assign n     = {24'h0, tim[23:16]} + 32'h1;
    assign cost  = n + (tim[2] ? 32'h1 + n * {28'h0, tim[7:4]} : 32'h0)
                 + (tim[1:0] == `ASM_PLOC_PE ? {28'h0, tim[11:8]} : 32'h0);
    assign legal = AVS_WRITEDATA_I[15:8] inside {`ASM_OPC_BORROW, `ASM_OPC_COND, `ASM_OPC_HIGH};

    // Shadow of the timing setup and length of the current busy run
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tim     <= 32'h0;
            run_len <= 32'h0;
        end else if (CE_I) begin
            if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == `ASM_OFS_TIMING) begin
                tim <= AVS_WRITEDATA_I;
            end
            run_len <= BUSY_O ? run_len + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);

    sequence instr_take;
        AVS_WRITE_I && AVS_WAITREQUEST_O && !BUSY_O && CE_I
            && AVS_ADDRESS_I == `ASM_OFS_INSTR && AVS_BYTEENABLE_I[1:0] == 2'h3;
    endsequence
    sequence busy_ends;
        BUSY_O ##1 !BUSY_O;
    endsequence

    wait_pulse_a: assert property (!AVS_WAITREQUEST_O && CE_I |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low longer than one cycle");
    read_answer_a: assert property (AVS_READ_I && AVS_WAITREQUEST_O && CE_I
        |=> !AVS_WAITREQUEST_O) else $error("read not answered next cycle");
    write_answer_a: assert property (AVS_WRITE_I && AVS_WAITREQUEST_O && !BUSY_O && CE_I
        |=> !AVS_WAITREQUEST_O) else $error("idle write not answered next cycle");
    write_stall_a: assert property (AVS_WRITE_I && BUSY_O |=> AVS_WAITREQUEST_O)
        else $error("write answered while busy");
    op_start_a: assert property (instr_take ##0 legal |=> BUSY_O)
        else $error("legal opcode did not start");
    bad_op_a: assert property (instr_take ##0 !legal |=> !BUSY_O)
        else $error("illegal opcode started");
    cycle_cost_a: assert property (busy_ends |-> run_len == cost)
        else $error("busy length differs from cycle cost");
    unmapped_zero_a: assert property (AVS_READ_I && !AVS_WAITREQUEST_O
        && AVS_ADDRESS_I inside {[12'h01c:12'h1fc]} |-> AVS_READDATA_O == 32'h0)
        else $error("unmapped read not zero");
endmodule : asm_top_asserts

bind asm_top asm_top_asserts #(.DM_AW(DM_AW)) u_asserts (
    .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .CE_I(CE_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .BUSY_O(BUSY_O)
);
`default_nettype wire

// ---- tb/asm_top_bench.sv ----
// Register-level tests of the subtract datapath
`timescale 1ns/1ps
`default_nettype none
`include "asm_cfg.svh"
module asm_top_bench;
    logic        clk;
    logic        arst_n;
    logic [11:0] addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        waitreq;
    logic [31:0] tm;
    logic        busy;
    int          num_errors;
    int          tests_run;

    asm_top #(.DM_AW(7)) u_dut (
        .CLK_I(clk), .ARST_N_I(arst_n), .CE_I(1'b1), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
        .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
        .BUSY_O(busy)
    );
    asm_host u_host (
        .clk_i(clk), .wait_i(waitreq), .rdata_i(rdata), .addr_o(addr), .rd_o(rd),
        .wr_o(wr), .wdata_o(wdata)
    );

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    task automatic close_out();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_host.access(1'b1, a, d, q);
    endtask : reg_wr

    task automatic reg_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        u_host.access(1'b0, a, 32'h0, q);
        check(q, e);
    endtask : reg_chk

    // Loads flags, accumulator and operand, runs one opcode, checks the accumulator
    task automatic op(input logic [31:0] ctrl, input logic [31:0] acc, input logic [15:0] w,
                      input logic [15:0] opc, input logic [31:0] exp);
        logic [31:0] st;
        reg_wr(`ASM_OFS_CTRL, ctrl);
        reg_wr(`ASM_OFS_ACC, acc);
        reg_wr(12'h200 + {3'h0, (opc[7] ? 7'h05 : opc[6:0]), 2'h0}, {16'h0, w});
        reg_wr(`ASM_OFS_INSTR, {16'h0, opc});
        check({31'h0, busy}, 32'h1);
        st = 32'h1;
        while (st[0] !== 1'b0) u_host.access(1'b0, `ASM_OFS_STATUS, 32'h0, st);
        check({31'h0, busy}, 32'h0);
        reg_chk(`ASM_OFS_ACC, exp);
    endtask : op

    initial begin
        #200000;
        num_errors++;
        close_out();
    end

    initial begin
        arst_n     = 1'b0;
        num_errors = 0;
        tests_run  = 0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        reg_chk(`ASM_OFS_CTRL, 32'h4);
        reg_chk(`ASM_OFS_ACC, 32'h0);
        reg_chk(`ASM_OFS_STATUS, 32'h0);
        reg_chk(`ASM_OFS_CYCLES, 32'h0);
        reg_wr(12'h01c, 32'h5a5a);
        reg_chk(12'h01c, 32'h0);
        reg_wr(`ASM_OFS_AUX, 32'h5);
        op(32'h0, 32'h6, 16'h6, {`ASM_OPC_BORROW, 8'h05}, 32'hffffffff);
        reg_chk(`ASM_OFS_CTRL, 32'h0);
        op(32'h4, 32'h10, 16'h2, {`ASM_OPC_BORROW, 8'h80}, 32'he);
        reg_chk(`ASM_OFS_CTRL, 32'h4);
        op(32'h6, 32'h80000000, 16'h1, {`ASM_OPC_BORROW, 8'h05}, 32'h80000000);
        reg_chk(`ASM_OFS_CTRL, 32'he);
        op(32'h4, 32'h80000000, 16'h1, {`ASM_OPC_BORROW, 8'h05}, 32'h7fffffff);
        reg_chk(`ASM_OFS_CTRL, 32'hc);
        op(32'h0, 32'h00051234, 16'h3, {`ASM_OPC_HIGH, 8'h05}, 32'h00021234);
        reg_chk(`ASM_OFS_CTRL, 32'h0);
        op(32'h4, 32'h00011234, 16'h2, {`ASM_OPC_HIGH, 8'h05}, 32'hffff1234);
        reg_chk(`ASM_OFS_CTRL, 32'h0);
        op(32'h6, 32'h80001111, 16'h1, {`ASM_OPC_HIGH, 8'h05}, 32'h80000000);
        reg_chk(`ASM_OFS_CTRL, 32'he);
        op(32'h0, 32'h40000000, 16'h8000, {`ASM_OPC_COND, 8'h05}, 32'h1);
        op(32'h1, 32'h40000000, 16'h8000, {`ASM_OPC_COND, 8'h05}, 32'h80000000);
        op(32'h2, 32'h7fffffff, 16'h0, {`ASM_OPC_COND, 8'h05}, 32'hffffffff);
        // Sixteen-step and pre-shifted eight-step division of 0x41 by 7
        reg_wr(`ASM_OFS_TIMING, 32'h000f0000);
        op(32'h0, 32'h41, 16'h7, {`ASM_OPC_COND, 8'h05}, 32'h00020009);
        op(32'h1, 32'h41, 16'h7, {`ASM_OPC_COND, 8'h05}, 32'h00020009);
        reg_chk(`ASM_OFS_CYCLES, 32'h10);
        reg_wr(`ASM_OFS_TIMING, 32'h00070000);
        op(32'h0, 32'h4100, 16'h7, {`ASM_OPC_COND, 8'h05}, 32'h00020009);
        reg_wr(`ASM_OFS_TIMING, 32'h0);
        reg_wr(`ASM_OFS_INSTR, 32'h1234);
        check({31'h0, busy}, 32'h0);
        reg_chk(`ASM_OFS_STATUS, 32'h2);
        op(32'h0, 32'h9, 16'h4, {`ASM_OPC_HIGH, 8'h05}, 32'hfffc0009);
        reg_chk(`ASM_OFS_STATUS, 32'h0);
        for (int pl = 0; pl < 3; pl++) begin
            for (int de = 0; de < 2; de++) begin
                for (int r = 0; r < 3; r += 2) begin
                    tm = {8'h0, 8'(r), 4'h0, 4'h2, 4'h3, 1'b0, 1'(de), 2'(pl)};
                    reg_wr(`ASM_OFS_TIMING, tm);
                    op(32'h0, 32'h0, 16'h0, {`ASM_OPC_HIGH, 8'h05}, 32'h0);
                    reg_chk(`ASM_OFS_CYCLES,
                            32'(r + 1 + de * (1 + (r + 1) * 3) + (pl == 1 ? 2 : 0)));
                end
            end
        end
        close_out();
    end
endmodule : asm_top_bench
`default_nettype wire
